// [adc_serial_config_port.sv]
// Purpose: Three-wire serial configuration port with pin-strap fallback.
// Assumes: clk at 20 MHz; serial pins asynchronous, far slower than clk.
// Notes: Pins are oversampled; shadowed bytes apply on a transfer command.

////////////////////////////////////////////////////////////////////////////
// How it works
// RL1: Transfers are accepted only while chip select is held low.
// RL2: Chip select fall then first serial clock rise starts the frame.
// RL3: Streaming length keeps accepting bytes while chip select stays low.
// RL4: Chip select high between bytes stalls a counted frame, which resumes afterwards; a streaming frame ends there instead.
// RL5: Before any select, data pin is released and pins act as straps.
// RL6: After the first select the port stays in serial mode for good.
// RL7: Each frame opens with a sixteen bit instruction.
// RL8: Two length bits of the instruction set the byte count.
// RL9: Data after the instruction moves in eight bit words.
// RL10: First instruction bit picks read or write.
// RL11: On read the data pin turns to output after the instruction.
// RL12: Data bits go MSB first until port config selects LSB first.
// RL13: Serial clock and chip select are inputs only.
// RL14: Data pin is input on writes, output only during readback.
// RL15: Bits shift only on the host serial clock.
// RL16: Host should keep the port idle during critical sampling.
// RL17: Unused port: pin levels are fixed configuration selections.
// RL18: Shadowed bytes apply together on transfer write; transfer bit clears.
// RL19: Bytes from the low to high shadow bound are held in shadow.
// RL20: Pin controls are ORed with their register bits.
// RL21: Sample on serial clock rise, change read data after its fall.
module adc_serial_config_port
    import adc_spi_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Serial port pins, also pin straps
    input wire logic serial_clock_or_format_strap,
    input wire logic chip_select_n,
    input wire logic serial_data_or_stabilizer_strap,
    output logic serial_data_out,
    output logic serial_data_oe_n,
    // Control pins and resulting configuration
    input wire pin_ctrl_s pin_ctrl,
    output cfg_s cfg
);

    state_s s;
    state_s next_s;
    logic rise;
    logic fall;
    logic sel;
    logic din;
    logic byte_done;
    logic [7:0] in_byte;
    pin_ctrl_s ctl;

    function automatic logic [7:0] read_byte(input state_s st,
                                             input logic [12:0] a);
        if (a < 13'(`MAP_WORDS)) begin
            read_byte = st.regs[a[`MAP_AW-1:0]];
        end else begin
            // Transfer bit reads as cleared; unmapped bytes read zero.
            read_byte = 8'h00;
        end
    endfunction : read_byte

    // Logic reads the second stage of each synchroniser; serial clock edge detect also uses the third stage.
    assign rise = s.sclk_sync[1] & ~s.sclk_sync[2];
    assign fall = ~s.sclk_sync[1] & s.sclk_sync[2];
    assign sel = s.sel_sync[1];
    assign din = s.sdio_sync[1];
    assign ctl = pin_ctrl_s'(s.ctl_sync[1]);
    assign byte_done = s.phase == data && rise && sel &&
                       s.bit_cnt == `WORD_LAST;
    assign in_byte = s.lsb_first ? {din, s.shreg[7:1]} :
                                   {s.shreg[6:0], din}; // RL12

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.sclk_sync = {s.sclk_sync[1:0], serial_clock_or_format_strap};
        // Stored active high so that reset cannot look like a select.
        next_s.sel_sync = {s.sel_sync[0], ~chip_select_n}; // RL13
        next_s.sdio_sync = {s.sdio_sync[0], serial_data_or_stabilizer_strap};
        next_s.ctl_sync = {s.ctl_sync[0], pin_ctrl};
        if (sel) begin
            next_s.serial_mode = 1'b1; // RL6
        end
        case (s.phase)
            idle: begin
                next_s.bit_cnt = 4'h0;
                if (sel) begin
                    next_s.phase = instr; // RL1 RL2
                end
            end
            instr: begin
                if (rise && sel) begin // RL15 RL21
                    next_s.shreg = {s.shreg[14:0], din};
                    next_s.bit_cnt = s.bit_cnt + 4'h1;
                    if (s.bit_cnt == `INSTR_LAST) begin // RL7
                        next_s.rw = s.shreg[14]; // RL10
                        next_s.bytes_left = s.shreg[13:12]; // RL8
                        next_s.stream = s.shreg[13:12] == `LEN_STREAM; // RL3
                        next_s.addr = {s.shreg[11:0], din};
                        next_s.bit_cnt = 4'h0;
                        next_s.phase = data;
                        next_s.shreg[15:8] =
                            read_byte(s, {s.shreg[11:0], din}); // RL11
                    end
                end
            end
            data: begin
                if (rise && sel) begin // RL9 RL15
                    next_s.bit_cnt = s.bit_cnt + 4'h1;
                    if (!s.rw) begin
                        next_s.shreg[7:0] = in_byte;
                    end
                end
                if (fall && sel && s.rw) begin // RL21
                    next_s.sdo = s.lsb_first ? s.shreg[8] : s.shreg[15];
                    next_s.shreg[15:8] = s.lsb_first ?
                        {1'b0, s.shreg[15:9]} : {s.shreg[14:8], 1'b0};
                end
                if (byte_done) begin
                    next_s.bit_cnt = 4'h0;
                    next_s.addr = s.addr + 13'h0001;
                    if (!s.rw) begin
                        if (s.addr == `TRANSFER_ADDR) begin
                            if (in_byte[`TRANSFER_BIT]) begin
                                // All shadowed bytes land in one edge.
                                for (int i = 0; i < `ACT_WORDS; i++) begin
                                    next_s.act[i] =
                                        s.regs[`SHADOW_LO + `MAP_AW'(i)]; // RL18
                                end
                            end
                        end else if (s.addr < 13'(`MAP_WORDS)) begin
                            next_s.regs[s.addr[`MAP_AW-1:0]] = in_byte; // RL19
                            if (s.addr == `PORT_CFG_ADDR) begin
                                next_s.lsb_first = in_byte[`LSB_FIRST_BIT];
                            end
                        end
                    end else begin
                        next_s.shreg[15:8] =
                            read_byte(s, s.addr + 13'h0001);
                    end
                    if (!s.stream) begin
                        if (s.bytes_left == 2'h0) begin
                            next_s.phase = done;
                        end else begin
                            next_s.bytes_left = s.bytes_left - 2'h1;
                        end
                    end
                end
                // A stream ends when select rises on a byte boundary.
                if (!sel && s.stream && s.bit_cnt == 4'h0) begin
                    next_s.phase = idle; // RL3 RL4
                end
            end
            done: begin
                if (!sel) begin
                    next_s.phase = idle;
                end
            end
            default: begin
                next_s.phase = idle;
            end
        endcase
        if (s.serial_mode) begin
            next_s.cfg.twos_complement =
                s.act[`OUT_MODE_ADDR - `SHADOW_LO][`TWOS_BIT];
            next_s.cfg.duty_stabilizer =
                s.act[`CLK_CFG_ADDR - `SHADOW_LO][`DCS_BIT];
        end else begin
            next_s.cfg.twos_complement = s.sclk_sync[1]; // RL5 RL17
            next_s.cfg.duty_stabilizer = s.sdio_sync[1]; // RL17
        end
        next_s.cfg.power_down = ctl.power_down |
            (s.act[`PWR_MODE_ADDR - `SHADOW_LO][1:0] != 2'h0); // RL20
        next_s.cfg.outputs_off = ctl.output_disable |
            s.act[`OUT_MODE_ADDR - `SHADOW_LO][`OUT_OFF_BIT]; // RL20
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign serial_data_out = s.sdo;
    // The pin is released in strap mode and on every write. RL5 RL14
    assign serial_data_oe_n = ~(s.serial_mode && sel &&
                                s.phase == data && s.rw); // RL11 RL14
    assign cfg = s.cfg;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence seq_write_byte(logic [12:0] a);
        byte_done && !s.rw && s.addr == a;
    endsequence

    a_mode_sticky: assert property (s.serial_mode |=> s.serial_mode) // RL6
        else $error("serial mode was left");
    a_strap_release: assert property (!s.serial_mode |-> // RL5
        serial_data_oe_n && cfg.duty_stabilizer == $past(s.sdio_sync[1]))
        else $error("strap mode drives data pin or ignores strap");
    a_drive_read: assert property (!serial_data_oe_n |-> // RL14
        s.rw && s.phase == data && sel)
        else $error("data pin driven outside readback");
    a_instr_len: assert property (s.phase == instr && rise && sel && // RL7
        s.bit_cnt == `INSTR_LAST |=> s.phase == data && s.bit_cnt == 4'h0)
        else $error("instruction phase not sixteen bits");
    a_shift_clock: assert property (s.phase != idle && !rise |=> // RL15
        $stable(s.bit_cnt) || s.phase == idle)
        else $error("bit counter moved without serial clock rise");
    a_sdo_on_fall: assert property ($changed(s.sdo) |-> $past(fall)) // RL21
        else $error("read data changed away from falling edge");
    a_transfer_apply: assert property ( // RL18
        seq_write_byte(`TRANSFER_ADDR) ##0 in_byte[`TRANSFER_BIT] |=>
        s.act[0] == s.regs[`SHADOW_LO] &&
        s.act[`ACT_WORDS-1] == s.regs[`SHADOW_HI] ##1
        s.cfg.outputs_off == (ctl.output_disable ||
            s.act[`OUT_MODE_ADDR - `SHADOW_LO][`OUT_OFF_BIT]))
        else $error("transfer did not apply shadow bytes");
    a_shadow_hold: assert property ( // RL19
        seq_write_byte(13'(`SHADOW_LO)) |=> $stable(s.act))
        else $error("shadowed write took effect early");
    a_bit_order: assert property (seq_write_byte(`PORT_CFG_ADDR) |=> // RL12
        s.lsb_first == $past(in_byte[`LSB_FIRST_BIT]))
        else $error("bit order not taken from port config");
    a_pin_or: assert property (ctl.power_down |=> cfg.power_down) // RL20
        else $error("power down pin not honoured");
    a_stream_on: assert property (byte_done && s.stream |=> // RL3
        s.phase == data)
        else $error("stream ended on byte count");
    a_stall_hold: assert property (s.phase == data && !sel && // RL4
        !s.stream |=> $stable(s.addr) && $stable(s.bit_cnt))
        else $error("frame advanced while deselected");
    a_frame_start: assert property (s.phase == idle && sel |=> // RL1 RL2
        s.phase == instr && s.bit_cnt == 4'h0)
        else $error("frame did not open on select");

endmodule : adc_serial_config_port

// [adc_spi_params.svh]
// Purpose: Offsets, field positions and counts of the serial config port.
// Assumes: Included by the package file only; the port module uses the macros without including it.
// Notes: Definitions only.
`ifndef ADC_SPI_PARAMS_SVH
`define ADC_SPI_PARAMS_SVH

`define INSTR_LAST 4'hF
`define WORD_LAST 4'h7
`define MAP_WORDS 32
`define MAP_AW 5
`define ACT_WORDS 17
`define PORT_CFG_ADDR 13'h0000
`define LSB_FIRST_BIT 6
`define TRANSFER_ADDR 13'h00FF
`define TRANSFER_BIT 0
`define SHADOW_LO 5'h08
`define SHADOW_HI 5'h18
`define PWR_MODE_ADDR 5'h08
`define CLK_CFG_ADDR 5'h09
`define DCS_BIT 0
`define OUT_MODE_ADDR 5'h14
`define TWOS_BIT 0
`define OUT_OFF_BIT 4
`define LEN_STREAM 2'h3

`endif

// [adc_spi_pkg.sv]
// Purpose: Types shared by the serial configuration port.
// Assumes: Widths come from adc_spi_params.svh.
// Notes: The whole port state is one packed struct.
`include "adc_spi_params.svh"

package adc_spi_pkg;

    typedef enum logic [1:0] {idle, instr, data, done} phase_e;

    typedef struct packed {
        logic power_down;
        logic output_disable;
    } pin_ctrl_s;

    typedef struct packed {
        logic twos_complement;
        logic duty_stabilizer;
        logic power_down;
        logic outputs_off;
    } cfg_s;

    typedef struct packed {
        logic [2:0] sclk_sync;
        logic [1:0] sel_sync;
        logic [1:0] sdio_sync;
        logic [1:0][1:0] ctl_sync;
        logic serial_mode;
        logic lsb_first;
        phase_e phase;
        logic [3:0] bit_cnt;
        logic rw;
        logic stream;
        logic [1:0] bytes_left;
        logic [12:0] addr;
        logic [15:0] shreg;
        logic sdo;
        cfg_s cfg;
        logic [`MAP_WORDS-1:0][7:0] regs;
        logic [`ACT_WORDS-1:0][7:0] act;
    } state_s;

endpackage : adc_spi_pkg

// [serial_host.sv]
// Purpose: Behavioural serial master for the configuration port.
// Assumes: Serial clock low 250 ns, high 150 ns, so a 400 ns period.
// Notes: A released data line toggles every clk so no stale bit survives.
module serial_host (
    // Clock
    input wire logic clk,
    // Pins driven toward the port
    output logic sclk,
    output logic csel_n,
    output logic line,
    // Port data output and its enable
    input wire logic dout,
    input wire logic doe_n,
    // Count of data pin direction faults
    output int oe_bad
);
    timeunit 1ns;
    timeprecision 100ps;
    logic hd = 1'b1;
    logic hoe_n = 1'b0;
    logic junk = 1'b0;

    // The port wins while it drives, so a short turnaround overlap is benign.
    assign line = !doe_n ? dout : (!hoe_n ? hd : junk);
    always @(posedge clk) junk <= ~line;
    initial begin
        sclk = 1'b1;
        csel_n = 1'b1;
        oe_bad = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One frame: instruction always MSB first, then nb data bytes.
    task frame(input logic [15:0] ins, input logic [15:0] wd, input int nb,
            input bit stall, output logic [15:0] rd);
        int i;
        logic rdir;
        rdir = ins[15];
        rd = '0;
        sclk = 1'b0;
        #300 csel_n = 1'b0;
        for (i = 0; i < 16 + 8 * nb; i++) begin
            if (stall && i == 24) begin
                #100 csel_n = 1'b1;
                #1000 csel_n = 1'b0;
            end
            hoe_n = rdir && i >= 16;
            hd = i < 16 ? ins[15 - i] : wd[31 - i];
            #250 sclk = 1'b1;
            if (i >= 16) begin
                rd[31 - i] = line;
                if (doe_n !== !rdir) oe_bad++;
            end
            #150 sclk = 1'b0;
        end
        #300 csel_n = 1'b1;
        hoe_n = 1'b0;
        hd = 1'b1;
        #600;
    endtask : frame
endmodule : serial_host

// [tb_top.sv]
// Purpose: Self-checking bench of the serial configuration port.
// Assumes: clk 50 ns; the host model times the serial pins on its own.
// Notes: Each scenario is a task that judges its own results.
module tb_top import adc_spi_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset_n;
    logic sclk, csel_n, line, dout, doe_n;
    pin_ctrl_s pins;
    cfg_s cfg;
    int oe_bad, failures, cmp_count;
    logic [15:0] rd;

    always #25 clk = ~clk;

    adc_serial_config_port DUT (.clk(clk), .reset_n(reset_n),
        .serial_clock_or_format_strap(sclk), .chip_select_n(csel_n),
        .serial_data_or_stabilizer_strap(line), .serial_data_out(dout),
        .serial_data_oe_n(doe_n), .pin_ctrl(pins), .cfg(cfg));
    serial_host host (.clk(clk), .sclk(sclk), .csel_n(csel_n), .line(line),
        .dout(dout), .doe_n(doe_n), .oe_bad(oe_bad));

    ////////////////////////////////////////////////////////////////////////
    task chk(input string name, input logic [15:0] exp,
            input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    task t_strap;
        chk("oe idle", 16'h1, {15'h0, doe_n});
        chk("strap cfg", 16'hC, {12'h0, cfg});
        @(posedge clk) pins <= 2'b11;
        tick(4);
        chk("pin or", 16'hF, {12'h0, cfg});
        @(posedge clk) pins <= 2'b00;
        tick(4);
    endtask : t_strap

    task t_shadow;
        host.frame(16'h0014, 16'h1100, 1, 0, rd);
        host.frame(16'h0008, 16'h0100, 1, 0, rd);
        chk("held", 16'h0, {12'h0, cfg});
        host.frame(16'h00FF, 16'h0100, 1, 0, rd);
        chk("applied", 16'hB, {12'h0, cfg});
        host.frame(16'h80FF, 16'h0, 1, 0, rd);
        chk("xfer clear", 16'h0, {8'h0, rd[15:8]});
        host.frame(16'h8014, 16'h0, 1, 0, rd);
        chk("read back", 16'h11, {8'h0, rd[15:8]});
    endtask : t_shadow

    task t_stream;
        host.frame(16'h2009, 16'h015A, 2, 1, rd);
        host.frame(16'h00FF, 16'h0100, 1, 0, rd);
        chk("stall write", 16'hF, {12'h0, cfg});
        host.frame(16'hE009, 16'h0, 2, 0, rd);
        chk("stream read", 16'h015A, rd);
    endtask : t_stream

    task t_lsb;
        host.frame(16'h0000, 16'h4000, 1, 0, rd);
        host.frame(16'h0014, 16'h0800, 1, 0, rd);
        // Data now goes bit 0 first, so the transfer byte is sent reversed.
        host.frame(16'h00FF, 16'h8000, 1, 0, rd);
        chk("lsb write", 16'h7, {12'h0, cfg});
        host.frame(16'h8014, 16'h0, 1, 0, rd);
        chk("lsb read", 16'h08, {8'h0, rd[15:8]});
        chk("pin dir", 16'h0, oe_bad[15:0]);
    endtask : t_lsb

    initial begin
        reset_n = 1'b0;
        pins = 2'b00;
        failures = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        tick(6);
        t_strap;
        t_shadow;
        t_stream;
        t_lsb;
        wrap_up;
    end

    // A hang anywhere ends the run as a mismatch.
    initial begin
        #2000000;
        failures++;
        wrap_up;
    end
endmodule : tb_top
